// File: inc/remappable_pin_select_pkg.sv
`default_nettype none
package remappable_pin_select_pkg;

    // ==========================================================
    // sizes
    localparam int PIN_COUNT = 16;
    localparam int SEL_W     = 4;
    localparam int IN_COUNT  = 10;
    localparam int OUT_COUNT = 7;

    // ==========================================================
    // peripheral input indexes
    localparam int IN_UART_RX  = 0;
    localparam int IN_UART_CTS = 1;
    localparam int IN_SPI_SDI  = 2;
    localparam int IN_SPI_SCK  = 3;
    localparam int IN_SPI_SS   = 4;
    localparam int IN_TMR_CK0  = 5;
    localparam int IN_TMR_CK1  = 6;
    localparam int IN_CAPT0    = 7;
    localparam int IN_CAPT1    = 8;
    localparam int IN_CHANGE0  = 9;

    localparam logic [SEL_W-1:0]    IN_INDEX_LIMIT = 4'ha;
    localparam logic [IN_COUNT-1:0] IN_IDLE        = 10'h013;

    // ==========================================================
    // output function codes
    localparam logic [SEL_W-1:0] OUT_NONE     = 4'h0;
    localparam logic [SEL_W-1:0] OUT_UART_TX  = 4'h1;
    localparam logic [SEL_W-1:0] OUT_UART_RTS = 4'h2;
    localparam logic [SEL_W-1:0] OUT_SPI_SDO  = 4'h3;
    localparam logic [SEL_W-1:0] OUT_SPI_SCK  = 4'h4;
    localparam logic [SEL_W-1:0] OUT_SPI_SS   = 4'h5;
    localparam logic [SEL_W-1:0] OUT_CMP0     = 4'h6;
    localparam logic [SEL_W-1:0] OUT_CMP1     = 4'h7;
    localparam logic [SEL_W-1:0] OUT_LAST     = OUT_CMP1;

    // ==========================================================
    // reset values and unlock keys
    localparam logic [SEL_W-1:0] IN_SEL_RESET  = 4'h0;
    localparam logic [SEL_W-1:0] OUT_SEL_RESET = OUT_NONE;
    localparam logic [SEL_W-1:0] UNLOCK_KEY0   = 4'ha;
    localparam logic [SEL_W-1:0] UNLOCK_KEY1   = 4'h5;

    // ==========================================================
    // types
    typedef enum logic [1:0] {CMD_IN_SEL, CMD_OUT_SEL, CMD_LOCK, CMD_KEY} cfg_cmd_t;

    typedef struct packed {
        logic             valid;
        cfg_cmd_t         cmd;
        logic [SEL_W-1:0] index;
        logic [SEL_W-1:0] value;
    } cfg_write_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pad_drive_t;

endpackage
`default_nettype wire

// File: rtl/input_route_mux.sv
`timescale 1ns/1ps
`default_nettype none
module input_route_mux #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    // clock and reset
    input  wire logic                                             clk,
    input  wire logic                                             sys_rst,
    // selection
    input  wire logic [remappable_pin_select_pkg::SEL_W-1:0]     sel,
    input  wire logic                                             assigned,
    // pins
    input  wire logic [remappable_pin_select_pkg::PIN_COUNT-1:0] pin_level,
    input  wire logic [remappable_pin_select_pkg::PIN_COUNT-1:0] pin_analog,
    // peripheral side
    output var  logic                                             data_reg
);

    logic data_next;

    // ==========================================================
    // pin pick
    always_comb begin
        data_next = IDLE_LEVEL;
        if (assigned) begin
            data_next = pin_level[sel] & ~pin_analog[sel];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_reg <= IDLE_LEVEL;
        end else begin
            data_reg <= data_next;
        end
    end

endmodule // input_route_mux
`default_nettype wire

// File: rtl/pin_owner_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module pin_owner_arbiter (
    // clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    sys_rst,
    // claimants
    input  wire logic                                    analog_en,
    input  wire logic                                    remap_active,
    input  wire remappable_pin_select_pkg::pad_drive_t   remap_drive,
    input  wire logic                                    fixed_en,
    input  wire remappable_pin_select_pkg::pad_drive_t   fixed_drive,
    input  wire remappable_pin_select_pkg::pad_drive_t   gpio_drive,
    // pad
    output var  remappable_pin_select_pkg::pad_drive_t   pad_reg,
    output var  logic                                    analog_reg
);

    remappable_pin_select_pkg::pad_drive_t pad_next;

    // ==========================================================
    // priority
    always_comb begin
        if (analog_en) begin
            pad_next = '0;
        end else if (remap_active) begin
            pad_next = remap_drive;
        end else if (fixed_en) begin
            pad_next = fixed_drive;
        end else begin
            pad_next = gpio_drive;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pad_reg    <= '0;
            analog_reg <= 1'b0;
        end else begin
            pad_reg    <= pad_next;
            analog_reg <= analog_en;
        end
    end

endmodule // pin_owner_arbiter
`default_nettype wire

// File: rtl/remappable_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select (
    // clock and reset
    input  wire logic                                                   clk,
    input  wire logic                                                   sys_rst,
    // configuration
    input  wire remappable_pin_select_pkg::cfg_write_t                  cfg_wr,
    output var  logic                                                   cfg_refused_reg,
    output var  logic                                                   map_locked_reg,
    // remappable peripherals
    output wire logic [remappable_pin_select_pkg::IN_COUNT-1:0]         periph_in,
    input  wire logic [remappable_pin_select_pkg::OUT_COUNT-1:0]        periph_out_en,
    input  wire remappable_pin_select_pkg::pad_drive_t [remappable_pin_select_pkg::OUT_COUNT-1:0] periph_out_drive,
    // port logic and fixed functions per pin
    input  wire remappable_pin_select_pkg::pad_drive_t [remappable_pin_select_pkg::PIN_COUNT-1:0] gpio_drive,
    input  wire logic [remappable_pin_select_pkg::PIN_COUNT-1:0]        fixed_en,
    input  wire remappable_pin_select_pkg::pad_drive_t [remappable_pin_select_pkg::PIN_COUNT-1:0] fixed_drive,
    input  wire logic [remappable_pin_select_pkg::PIN_COUNT-1:0]        analog_en,
    output var  logic [remappable_pin_select_pkg::PIN_COUNT-1:0]        digital_in_reg,
    // pads
    input  wire logic [remappable_pin_select_pkg::PIN_COUNT-1:0]        pad_in,
    output wire remappable_pin_select_pkg::pad_drive_t [remappable_pin_select_pkg::PIN_COUNT-1:0] pad_drive,
    output wire logic [remappable_pin_select_pkg::PIN_COUNT-1:0]        pad_analog
);

    localparam int PN = remappable_pin_select_pkg::PIN_COUNT;
    localparam int IN = remappable_pin_select_pkg::IN_COUNT;
    localparam int ON = remappable_pin_select_pkg::OUT_COUNT;
    localparam int SW = remappable_pin_select_pkg::SEL_W;

    typedef enum logic [1:0] {ST_OPEN, ST_LOCKED, ST_HALF_KEY} lock_state_t;

    // ==========================================================
    // output code decode
    function automatic logic code_active(input logic [SW-1:0] code, input logic [ON-1:0] en);
        logic [SW-1:0] idx;
        idx = code - 4'h1;
        code_active = 1'b0;
        if (code != remappable_pin_select_pkg::OUT_NONE && code <= remappable_pin_select_pkg::OUT_LAST) begin
            code_active = en[idx[2:0]];
        end
    endfunction

    function automatic remappable_pin_select_pkg::pad_drive_t code_drive(
        input logic [SW-1:0] code,
        input remappable_pin_select_pkg::pad_drive_t [ON-1:0] drv
    );
        logic [SW-1:0] idx;
        idx = code - 4'h1;
        code_drive = '0;
        if (code != remappable_pin_select_pkg::OUT_NONE && code <= remappable_pin_select_pkg::OUT_LAST) begin
            code_drive = drv[idx[2:0]];
        end
    endfunction

    // ==========================================================
    // configuration state
    lock_state_t   lock_reg;
    lock_state_t   lock_next;
    logic [SW-1:0] in_sel_reg   [IN];
    logic [SW-1:0] in_sel_next  [IN];
    logic [IN-1:0] assigned_reg;
    logic [IN-1:0] assigned_next;
    logic [SW-1:0] out_sel_reg  [PN];
    logic [SW-1:0] out_sel_next [PN];
    logic          refused_next;

    always_comb begin
        lock_next     = lock_reg;
        in_sel_next   = in_sel_reg;
        assigned_next = assigned_reg;
        out_sel_next  = out_sel_reg;
        refused_next  = 1'b0;
        if (cfg_wr.valid) begin
            case (lock_reg)
                ST_OPEN: begin
                    case (cfg_wr.cmd)
                        remappable_pin_select_pkg::CMD_IN_SEL: begin
                            if (cfg_wr.index < remappable_pin_select_pkg::IN_INDEX_LIMIT) begin
                                in_sel_next[cfg_wr.index]   = cfg_wr.value;
                                assigned_next[cfg_wr.index] = 1'b1;
                            end else begin
                                refused_next = 1'b1;
                            end
                        end
                        remappable_pin_select_pkg::CMD_OUT_SEL: begin
                            out_sel_next[cfg_wr.index] = cfg_wr.value;
                        end
                        remappable_pin_select_pkg::CMD_LOCK: begin
                            lock_next = ST_LOCKED;
                        end
                        default: begin
                            lock_next = ST_OPEN;
                        end
                    endcase
                end
                ST_LOCKED: begin
                    if (cfg_wr.cmd == remappable_pin_select_pkg::CMD_KEY
                        && cfg_wr.value == remappable_pin_select_pkg::UNLOCK_KEY0) begin
                        lock_next = ST_HALF_KEY;
                    end else begin
                        refused_next = 1'b1;
                    end
                end
                ST_HALF_KEY: begin
                    if (cfg_wr.cmd == remappable_pin_select_pkg::CMD_KEY
                        && cfg_wr.value == remappable_pin_select_pkg::UNLOCK_KEY1) begin
                        lock_next = ST_OPEN;
                    end else begin
                        lock_next    = ST_LOCKED;
                        refused_next = 1'b1;
                    end
                end
                default: begin
                    lock_next = ST_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_reg        <= ST_OPEN;
            assigned_reg    <= '0;
            cfg_refused_reg <= 1'b0;
            map_locked_reg  <= 1'b0;
            for (int i = 0; i < IN; i++) begin
                in_sel_reg[i] <= remappable_pin_select_pkg::IN_SEL_RESET;
            end
            for (int p = 0; p < PN; p++) begin
                out_sel_reg[p] <= remappable_pin_select_pkg::OUT_SEL_RESET;
            end
        end else begin
            lock_reg        <= lock_next;
            assigned_reg    <= assigned_next;
            cfg_refused_reg <= refused_next;
            map_locked_reg  <= (lock_next != ST_OPEN);
            in_sel_reg      <= in_sel_next;
            out_sel_reg     <= out_sel_next;
        end
    end

    // ==========================================================
    // pad input synchroniser
    logic [PN-1:0] pad_meta_reg;
    logic [PN-1:0] pad_sync_reg;
    logic [PN-1:0] digital_in_next;

    always_comb begin
        digital_in_next = pad_sync_reg & ~analog_en;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pad_meta_reg   <= '0;
            pad_sync_reg   <= '0;
            digital_in_reg <= '0;
        end else begin
            pad_meta_reg   <= pad_in;
            pad_sync_reg   <= pad_meta_reg;
            digital_in_reg <= digital_in_next;
        end
    end

    // ==========================================================
    // input routing
    generate
        for (genvar g = 0; g < IN; g++) begin : g_in
            input_route_mux #(
                .IDLE_LEVEL (remappable_pin_select_pkg::IN_IDLE[g])
            ) u_mux (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .sel        (in_sel_reg[g]),
                .assigned   (assigned_reg[g]),
                .pin_level  (pad_sync_reg),
                .pin_analog (analog_en),
                .data_reg   (periph_in[g])
            );
        end
    endgenerate

    // ==========================================================
    // output routing and pin ownership
    generate
        for (genvar p = 0; p < PN; p++) begin : g_pin
            logic                                  remap_active;
            remappable_pin_select_pkg::pad_drive_t remap_drive;

            assign remap_active = code_active(out_sel_reg[p], periph_out_en);
            assign remap_drive  = code_drive(out_sel_reg[p], periph_out_drive);

            pin_owner_arbiter u_arb (
                .clk          (clk),
                .sys_rst      (sys_rst),
                .analog_en    (analog_en[p]),
                .remap_active (remap_active),
                .remap_drive  (remap_drive),
                .fixed_en     (fixed_en[p]),
                .fixed_drive  (fixed_drive[p]),
                .gpio_drive   (gpio_drive[p]),
                .pad_reg      (pad_drive[p]),
                .analog_reg   (pad_analog[p])
            );
        end
    endgenerate

endmodule // remappable_pin_select
`default_nettype wire

// File: verif/remappable_pin_select_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select_monitor (
    // clock and reset
    input wire logic                                          clk,
    input wire logic                                          sys_rst,
    // watched ports
    input wire remappable_pin_select_pkg::cfg_write_t         cfg_wr,
    input wire logic                                          cfg_refused_reg,
    input wire logic                                          map_locked_reg,
    input wire logic [9:0]                                    periph_in,
    input wire logic [6:0]                                    periph_out_en,
    input wire remappable_pin_select_pkg::pad_drive_t [15:0]  gpio_drive,
    input wire logic [15:0]                                   fixed_en,
    input wire remappable_pin_select_pkg::pad_drive_t [15:0]  fixed_drive,
    input wire logic [15:0]                                   analog_en,
    input wire logic [15:0]                                   digital_in_reg,
    input wire remappable_pin_select_pkg::pad_drive_t [15:0]  pad_drive,
    input wire logic [15:0]                                   pad_analog
);
    // ==========================================================
    // helper logic
    logic [15:0]                                   oe_w;
    remappable_pin_select_pkg::pad_drive_t [15:0]  exp_w;
    logic                                          seen_sel_reg;
    logic                                          seen_sel_next;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            oe_w[i] = pad_drive[i].oe;
            exp_w[i] = fixed_en[i] ? fixed_drive[i] : gpio_drive[i];
        end
        seen_sel_next = seen_sel_reg | (cfg_wr.valid && cfg_wr.cmd == remappable_pin_select_pkg::CMD_IN_SEL);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_sel_reg <= 1'b0;
        end else begin
            seen_sel_reg <= seen_sel_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // properties
    property p_analog_drive;
        analog_en != 16'h0 |=> (oe_w & $past(analog_en)) == 16'h0;
    endproperty
    a_analog_drive: assert property (p_analog_drive) else $error("analog pin driven");
    property p_analog_copy;
        1'b1 |=> pad_analog == $past(analog_en);
    endproperty
    a_analog_copy: assert property (p_analog_copy) else $error("analog claim lost");
    property p_digital_analog;
        1'b1 |=> (digital_in_reg & $past(analog_en)) == 16'h0;
    endproperty
    a_digital_analog: assert property (p_digital_analog) else $error("digital read on analog pin");
    property p_fixed_gpio;
        periph_out_en == 7'h0 && analog_en == 16'h0 |=> pad_drive == $past(exp_w);
    endproperty
    a_fixed_gpio: assert property (p_fixed_gpio) else $error("pad not fixed or port drive");
    property p_lock_refuse;
        map_locked_reg && cfg_wr.valid && cfg_wr.cmd != remappable_pin_select_pkg::CMD_KEY |=> cfg_refused_reg;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("locked write not refused");
    property p_lock_hold;
        map_locked_reg && !(cfg_wr.valid && cfg_wr.cmd == remappable_pin_select_pkg::CMD_KEY
            && cfg_wr.value == remappable_pin_select_pkg::UNLOCK_KEY1) |=> map_locked_reg;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
    property p_lock_set;
        !map_locked_reg && cfg_wr.valid && cfg_wr.cmd == remappable_pin_select_pkg::CMD_LOCK |=> map_locked_reg;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not taken");
    property p_range_refuse;
        !map_locked_reg && cfg_wr.valid && cfg_wr.cmd == remappable_pin_select_pkg::CMD_IN_SEL
            && cfg_wr.index >= remappable_pin_select_pkg::IN_INDEX_LIMIT |=> cfg_refused_reg;
    endproperty
    a_range_refuse: assert property (p_range_refuse) else $error("bad input index taken");
    property p_idle;
        !seen_sel_reg |-> periph_in == remappable_pin_select_pkg::IN_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("unassigned input not idle");
endmodule // remappable_pin_select_monitor

bind remappable_pin_select remappable_pin_select_monitor u_monitor (
    .clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_refused_reg(cfg_refused_reg),
    .map_locked_reg(map_locked_reg), .periph_in(periph_in), .periph_out_en(periph_out_en),
    .gpio_drive(gpio_drive), .fixed_en(fixed_en), .fixed_drive(fixed_drive), .analog_en(analog_en),
    .digital_in_reg(digital_in_reg), .pad_drive(pad_drive), .pad_analog(pad_analog)
);
`default_nettype wire

// File: verif/pad_world.sv
`timescale 1ns/1ps
`default_nettype none
module pad_world (
    // pads toward the block
    input  wire remappable_pin_select_pkg::pad_drive_t [15:0] pad_drive,
    output var  logic [15:0]                                  pad_in,
    // board levels
    input  wire logic [15:0]                                  ext_level
);
    // driven pads read back their own level
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad_in[i] = pad_drive[i].oe ? pad_drive[i].out : ext_level[i];
        end
    end
endmodule // pad_world
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {int cyc; int kind; int idx; logic [1:0] v;} note_t;
    logic                                          clk, sys_rst, cfg_refused_reg, map_locked_reg;
    remappable_pin_select_pkg::cfg_write_t         cfg_wr;
    logic [9:0]                                    periph_in;
    logic [6:0]                                    periph_out_en;
    remappable_pin_select_pkg::pad_drive_t [6:0]   periph_out_drive;
    remappable_pin_select_pkg::pad_drive_t [15:0]  gpio_drive, fixed_drive, pad_drive;
    logic [15:0]                                   fixed_en, analog_en, digital_in_reg, pad_in, pad_analog, ext_level;
    logic [7:0]                                    seed = 8'h60;
    logic [3:0]                                    sel0, p;
    int                                            cyc, mismatches, n_compared;
    note_t                                         q[$];

    remappable_pin_select u_remappable_pin_select (
        .clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_refused_reg(cfg_refused_reg),
        .map_locked_reg(map_locked_reg), .periph_in(periph_in), .periph_out_en(periph_out_en),
        .periph_out_drive(periph_out_drive), .gpio_drive(gpio_drive), .fixed_en(fixed_en),
        .fixed_drive(fixed_drive), .analog_en(analog_en), .digital_in_reg(digital_in_reg),
        .pad_in(pad_in), .pad_drive(pad_drive), .pad_analog(pad_analog)
    );
    pad_world u_pad_world (.pad_drive(pad_drive), .pad_in(pad_in), .ext_level(ext_level));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction
    function logic pin_lvl(input logic [3:0] n);
        return gpio_drive[n].oe ? gpio_drive[n].out : ext_level[n];
    endfunction
    task note(input int d, input int k, input int i, input logic [1:0] v);
        q.push_back('{cyc + d, k, i, v});
    endtask
    task cfg(input remappable_pin_select_pkg::cfg_cmd_t c, input logic [3:0] i, input logic [3:0] v);
        @(negedge clk);
        cfg_wr = '{1'b1, c, i, v};
    endtask
    task idle(input int n);
        repeat (n) begin
            @(negedge clk);
            cfg_wr.valid = 1'b0;
        end
    endtask
    task chk1(input string s, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", s, e, g);
        end
    endtask
    task chk2(input string s, input logic [1:0] e, input logic [1:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", s, e, g);
        end
    endtask
    task rst_chk();
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (i < 10) note(1, 2, i, remappable_pin_select_pkg::IN_IDLE[i]);
            note(1, 3, i, gpio_drive[i]);
        end
    endtask
    task end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // watcher takes due notes and compares
    always @(posedge clk) begin
        note_t n;
        cyc = cyc + 1;
        #1;
        while (q.size() > 0 && q[0].cyc <= cyc) begin
            n = q.pop_front();
            case (n.kind)
                0: chk1("refused", n.v[0], cfg_refused_reg);
                1: chk1("locked", n.v[0], map_locked_reg);
                2: chk1("periph_in", n.v[0], periph_in[n.idx]);
                4: chk1("digital_in", n.v[0], digital_in_reg[n.idx]);
                default: chk2("pad_drive", n.v, pad_drive[n.idx]);
            endcase
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    // ==========================================================
    // stimulus
    initial begin
        sys_rst = 1'b1;
        cfg_wr = '0;
        periph_out_en = '0;
        periph_out_drive = '0;
        fixed_en = '0;
        fixed_drive = '0;
        analog_en = '0;
        gpio_drive = {rnd(), rnd(), rnd(), rnd()};
        ext_level = {rnd(), rnd()};
        rst_chk();
        idle(2);
        for (int k = 0; k < 10; k++) begin
            p = 4'(rnd());
            ext_level = {rnd(), rnd()};
            if (k == 0) sel0 = p;
            cfg(remappable_pin_select_pkg::CMD_IN_SEL, 4'(k), p);
            note(3, 2, k, pin_lvl(p));
            note(3, 4, p, pin_lvl(p));
            idle(3);
        end
        for (int i = 10; i < 16; i++) begin
            cfg(remappable_pin_select_pkg::CMD_IN_SEL, 4'(i), 4'h0);
            note(1, 0, 0, 2'h1);
        end
        idle(1);
        note(1, 0, 0, 2'h0);
        idle(2);
        analog_en[sel0] = 1'b1;
        note(1, 3, sel0, 2'h0);
        note(3, 2, 0, 2'h0);
        idle(3);
        analog_en = '0;
        for (int c = 1; c < 8; c++) begin
            p = 4'(c + 8);
            cfg(remappable_pin_select_pkg::CMD_OUT_SEL, p, 4'(c));
            fixed_en[p] = 1'b1;
            fixed_drive[p] = 2'(rnd());
            periph_out_en[c - 1] = 1'b1;
            periph_out_drive[c - 1] = 2'(rnd()) | 2'h1;
            note(1, 3, p, fixed_drive[p]);
            note(2, 3, p, periph_out_drive[c - 1]);
            idle(2);
            periph_out_en[c - 1] = 1'b0;
            note(1, 3, p, fixed_drive[p]);
            idle(1);
            fixed_en[p] = 1'b0;
            note(1, 3, p, gpio_drive[p]);
            idle(1);
        end
        cfg(remappable_pin_select_pkg::CMD_KEY, 4'h0, remappable_pin_select_pkg::UNLOCK_KEY0);
        note(1, 0, 0, 2'h0);
        cfg(remappable_pin_select_pkg::CMD_LOCK, 4'h0, 4'h0);
        note(1, 1, 0, 2'h1);
        p = sel0;
        for (int j = 0; j < 16; j++) begin
            if (pin_lvl(4'(j)) != pin_lvl(sel0)) p = 4'(j);
        end
        cfg(remappable_pin_select_pkg::CMD_IN_SEL, 4'h0, p);
        note(1, 0, 0, 2'h1);
        cfg(remappable_pin_select_pkg::CMD_KEY, 4'h0, remappable_pin_select_pkg::UNLOCK_KEY0);
        cfg(remappable_pin_select_pkg::CMD_OUT_SEL, 4'h0, 4'h0);
        note(1, 0, 0, 2'h1);
        note(1, 1, 0, 2'h1);
        cfg(remappable_pin_select_pkg::CMD_KEY, 4'h0, remappable_pin_select_pkg::UNLOCK_KEY0);
        cfg(remappable_pin_select_pkg::CMD_KEY, 4'h0, 4'h3);
        note(1, 0, 0, 2'h1);
        note(1, 1, 0, 2'h1);
        cfg(remappable_pin_select_pkg::CMD_KEY, 4'h0, remappable_pin_select_pkg::UNLOCK_KEY0);
        cfg(remappable_pin_select_pkg::CMD_KEY, 4'h0, remappable_pin_select_pkg::UNLOCK_KEY1);
        note(1, 1, 0, 2'h0);
        idle(1);
        note(1, 2, 0, pin_lvl(sel0));
        idle(2);
        cfg(remappable_pin_select_pkg::CMD_OUT_SEL, 4'h9, 4'h8);
        idle(1);
        periph_out_en = '1;
        note(1, 3, 9, gpio_drive[9]);
        note(1, 3, 10, periph_out_drive[1]);
        idle(1);
        periph_out_en = '0;
        idle(1);
        rst_chk();
        for (int k = 0; k < 20 && q.size() > 0; k++) @(posedge clk);
        if (q.size() > 0) mismatches++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
